// ### core/lsps_pkg.sv
package lsps_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       ck;
    logic       fs;
    logic       ssf;
    logic       ssd;
  } lsps_cp_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ck;
    logic       fs;
    logic       ssf;
  } lsps_cp_out_t;

  typedef struct packed {
    logic [3:0] req;
    logic [3:0] chan;
    logic [3:0] bridge;
    logic       arch_n;
  } lsps_aps_t;

  typedef struct packed {
    logic [1:0] null_mode;
    logic [3:0] null_ch;
    logic       sd_prio;
    logic       sf_prio;
    logic       spare_en;
    logic       revert;
    logic       bidir;
    logic       arch_1p1;
  } lsps_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_SWITCHED = 3'h1,
    ST_WTR      = 3'h3,
    ST_HOLD     = 3'h2,
    ST_LOCK     = 3'h6
  } lsps_state_t;

  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_CMD      = 8'h04;
  localparam logic [7:0]  ADDR_WTR      = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
  localparam logic [7:0]  ADDR_EVCNT    = 8'h10;
  localparam logic [7:0]  ADDR_DURCNT   = 8'h14;
  localparam logic [7:0]  ADDR_INTSTAT  = 8'h18;
  localparam logic [7:0]  ADDR_INTMASK  = 8'h1C;

  localparam logic [11:0] CTRL_RST      = 12'h005;
  localparam logic [9:0]  WTR_RST       = 10'h12C;
  localparam logic [9:0]  WTR_MAX_S     = 10'h2D0;

  localparam logic [2:0]  CMD_CLR       = 3'h0;
  localparam logic [2:0]  CMD_LO        = 3'h1;
  localparam logic [2:0]  CMD_FS        = 3'h2;
  localparam logic [2:0]  CMD_MS        = 3'h3;
  localparam logic [2:0]  CMD_EXER      = 3'h4;

  localparam logic [3:0]  REQ_NR        = 4'h0;
  localparam logic [3:0]  REQ_DNR       = 4'h1;
  localparam logic [3:0]  REQ_EXER      = 4'h4;
  localparam logic [3:0]  REQ_WTR       = 4'h6;
  localparam logic [3:0]  REQ_MS        = 4'h8;
  localparam logic [3:0]  REQ_SD_LO     = 4'h9;
  localparam logic [3:0]  REQ_SD        = 4'hA;
  localparam logic [3:0]  REQ_SF_LO     = 4'hB;
  localparam logic [3:0]  REQ_SF        = 4'hC;
  localparam logic [3:0]  REQ_FS        = 4'hD;
  localparam logic [3:0]  REQ_SFP       = 4'hE;
  localparam logic [3:0]  REQ_LO        = 4'hF;

  localparam logic [1:0]  NULL_ONES     = 2'h0;
  localparam logic [1:0]  NULL_NORMAL   = 2'h1;
  localparam logic [1:0]  NULL_TEST     = 2'h2;

  localparam int          INT_SWITCH    = 0;
  localparam int          INT_FOP       = 1;
  localparam int          INT_WTR       = 2;
  localparam int          INT_W         = 3;

  localparam int          CLK_KHZ       = 100000;
  localparam int          TICK_TIME_MS  = 1000;
  localparam int          FOP_TIME_MS   = 50;
  localparam int          TICK_CYC_DEF  = TICK_TIME_MS * CLK_KHZ;
  localparam int          FOP_CYC_DEF   = FOP_TIME_MS * CLK_KHZ;

endpackage

// ### core/lsps_core.sv
`timescale 1ns/1ps
module lsps_core #(
  parameter int N_CH     = 14,
  parameter int TICK_CYC = lsps_pkg::TICK_CYC_DEF,
  parameter int FOP_CYC  = lsps_pkg::FOP_CYC_DEF
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               clk_en,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  output logic                                    irq,
  input  wire lsps_pkg::lsps_cp_in_t [N_CH-1:0]   work_in,
  input  wire lsps_pkg::lsps_cp_in_t [N_CH-1:0]   norm_in,
  input  wire lsps_pkg::lsps_cp_in_t              prot_in,
  input  wire lsps_pkg::lsps_cp_in_t              xtra_in,
  input  wire logic [12:0]                        aps_rx,
  output lsps_pkg::lsps_cp_out_t [N_CH-1:0]       norm_out,
  output lsps_pkg::lsps_cp_out_t [N_CH-1:0]       work_out,
  output lsps_pkg::lsps_cp_out_t                  prot_out,
  output lsps_pkg::lsps_cp_out_t                  xtra_out,
  output logic [12:0]                             aps_tx,
  output logic                                    protocol_failure_flag
);

  localparam int NIN  = 2 * N_CH + 2;
  localparam int IP   = 2 * N_CH;
  localparam int IX   = 2 * N_CH + 1;
  localparam int INT_W_L = lsps_pkg::INT_W;

  lsps_pkg::lsps_cp_in_t  in_all [NIN];
  lsps_pkg::lsps_cp_in_t  s1_reg [NIN];
  lsps_pkg::lsps_cp_in_t  s2_reg [NIN];
  lsps_pkg::lsps_cp_in_t  cap_reg [NIN];
  logic                   ckd_reg [NIN];
  logic [12:0]            aps_s1_reg;
  logic [12:0]            aps_s2_reg;
  logic [12:0]            aps_s3_reg;
  lsps_pkg::lsps_aps_t    aps_rx_reg;
  lsps_pkg::lsps_ctrl_t   ctrl_reg;
  logic [2:0]             cmd_code_reg;
  logic [3:0]             cmd_ch_reg;
  logic [9:0]             wtr_period_reg;
  logic [3:0]             sel_reg;
  logic [3:0]             sel_next;
  logic [3:0]             req_next;
  logic [3:0]             req_ch;
  lsps_pkg::lsps_state_t  state_reg;
  lsps_pkg::lsps_state_t  state_next;
  logic [9:0]             wtr_cnt_reg;
  logic [31:0]            tick_cnt_reg;
  logic                   tick;
  logic [31:0]            fop_cnt_reg;
  logic                   fop_bad;
  logic [31:0]            ev_cnt_reg;
  logic [31:0]            dur_cnt_reg;
  logic [INT_W_L-1:0]     int_stat_reg;
  logic [INT_W_L-1:0]     int_mask_reg;
  logic [INT_W_L-1:0]     int_set;
  logic [7:0]             test_reg;
  logic [3:0]             nw;
  logic                   revert_eff;
  logic                   wr_en;
  logic [31:0]            rdata;
  lsps_pkg::lsps_aps_t    aps_tx_reg;

  // Gather all ingress points into one array
  for (genvar k = 0; k < N_CH; k++)
  begin : g_map
    assign in_all[k]        = work_in[k];
    assign in_all[N_CH + k] = norm_in[k];
  end
  assign in_all[IP] = prot_in;
  assign in_all[IX] = xtra_in;

  // Two-stage sync then capture on the sampled link clock edge
  for (genvar k = 0; k < NIN; k++)
  begin : g_sync
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        s1_reg[k]  <= '0;
        s2_reg[k]  <= '0;
        cap_reg[k] <= '0;
        ckd_reg[k] <= 1'b0;
      end
      else if (clk_en)
      begin
        s1_reg[k]  <= in_all[k];
        s2_reg[k]  <= s1_reg[k];
        ckd_reg[k] <= s2_reg[k].ck;
        if (s2_reg[k].ck && !ckd_reg[k])
          cap_reg[k] <= s2_reg[k];
      end
    end
  end

  function automatic lsps_pkg::lsps_cp_out_t fwd(
    input lsps_pkg::lsps_cp_in_t c,
    input logic                  ck
  );
    fwd = '{data: c.data, ck: ck, fs: c.fs, ssf: c.ssf};
  endfunction

  // Received signalling word, taken when two samples agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      aps_s1_reg <= '0;
      aps_s2_reg <= '0;
      aps_s3_reg <= '0;
      aps_rx_reg <= '0;
    end
    else if (clk_en)
    begin
      aps_s1_reg <= aps_rx;
      aps_s2_reg <= aps_s1_reg;
      aps_s3_reg <= aps_s2_reg;
      if (aps_s3_reg == aps_s2_reg)
        aps_rx_reg <= aps_s3_reg;
    end
  end

  assign nw         = ctrl_reg.arch_1p1 ? 4'h1 : 4'(N_CH);
  assign revert_eff = ctrl_reg.revert || !ctrl_reg.arch_1p1;

  // Request arbitration and selector decision
  always_comb
  begin
    logic [3:0] c;
    logic [3:0] cch;
    c        = lsps_pkg::REQ_NR;
    req_next = lsps_pkg::REQ_NR;
    req_ch   = 4'h0;
    cch      = ctrl_reg.arch_1p1 ? 4'h1 : cmd_ch_reg;
    for (int i = 0; i < N_CH; i++)
    begin
      if (4'(i) < nw)
      begin
        if (cap_reg[i].ssf)
          c = ctrl_reg.sf_prio ? lsps_pkg::REQ_SF : lsps_pkg::REQ_SF_LO;
        else if (cap_reg[i].ssd)
          c = ctrl_reg.sd_prio ? lsps_pkg::REQ_SD : lsps_pkg::REQ_SD_LO;
        else
          c = lsps_pkg::REQ_NR;
        if (c > req_next)
        begin
          req_next = c;
          req_ch   = 4'(i + 1);
        end
      end
    end
    if (cch != 4'h0 && cch <= nw)
    begin
      case (cmd_code_reg)
        lsps_pkg::CMD_FS:
          if (lsps_pkg::REQ_FS > req_next)
          begin
            req_next = lsps_pkg::REQ_FS;
            req_ch   = cch;
          end
        lsps_pkg::CMD_MS:
          if (lsps_pkg::REQ_MS > req_next)
          begin
            req_next = lsps_pkg::REQ_MS;
            req_ch   = cch;
          end
        lsps_pkg::CMD_EXER:
          if (lsps_pkg::REQ_EXER > req_next)
          begin
            req_next = lsps_pkg::REQ_EXER;
            req_ch   = cch;
          end
        default:
          req_next = req_next;
      endcase
    end
    if (ctrl_reg.bidir && aps_rx_reg.req > req_next &&
        aps_rx_reg.chan != 4'h0 && aps_rx_reg.chan <= nw)
    begin
      req_next = aps_rx_reg.req;
      req_ch   = aps_rx_reg.chan;
    end
    if (req_next < lsps_pkg::REQ_WTR && sel_reg != 4'h0 &&
        req_next != lsps_pkg::REQ_EXER)
    begin
      if (!revert_eff)
        req_next = lsps_pkg::REQ_DNR;
      else if (state_reg != lsps_pkg::ST_WTR || wtr_cnt_reg != 10'h000)
        req_next = lsps_pkg::REQ_WTR;
      req_ch = (req_next == lsps_pkg::REQ_NR) ? 4'h0 : sel_reg;
    end
    if (cmd_code_reg == lsps_pkg::CMD_LO)
    begin
      req_next = lsps_pkg::REQ_LO;
      req_ch   = 4'h0;
    end
    else if (cap_reg[IP].ssf)
    begin
      req_next = lsps_pkg::REQ_SFP;
      req_ch   = 4'h0;
    end
    // Only real requests move the selector, so config writes do not
    sel_next = (req_next >= lsps_pkg::REQ_WTR &&
                req_next != lsps_pkg::REQ_SFP &&
                req_next != lsps_pkg::REQ_LO) ||
               req_next == lsps_pkg::REQ_DNR ? req_ch : 4'h0;
    case (req_next)
      lsps_pkg::REQ_LO,
      lsps_pkg::REQ_SFP: state_next = lsps_pkg::ST_LOCK;
      lsps_pkg::REQ_WTR: state_next = lsps_pkg::ST_WTR;
      lsps_pkg::REQ_DNR: state_next = lsps_pkg::ST_HOLD;
      default:
        state_next = (sel_next != 4'h0) ? lsps_pkg::ST_SWITCHED
                                        : lsps_pkg::ST_IDLE;
    endcase
  end

  // Selector and state update in a single cycle, no hold-off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_reg    <= 4'h0;
      state_reg  <= lsps_pkg::ST_IDLE;
      aps_tx_reg <= '0;
    end
    else if (clk_en)
    begin
      sel_reg    <= sel_next;
      state_reg  <= state_next;
      aps_tx_reg <= '{req: req_next, chan: req_ch, bridge: sel_next,
                      arch_n: !ctrl_reg.arch_1p1};
    end
  end
  assign aps_tx = aps_tx_reg;

  // One second tick and wait-to-restore timer
  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      wtr_cnt_reg  <= 10'h000;
    end
    else if (clk_en)
    begin
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
      if (state_next != lsps_pkg::ST_WTR)
        wtr_cnt_reg <= (wtr_period_reg > lsps_pkg::WTR_MAX_S) ?
                       lsps_pkg::WTR_MAX_S : wtr_period_reg;
      else if (state_reg == lsps_pkg::ST_WTR && tick &&
               wtr_cnt_reg != 10'h000)
        wtr_cnt_reg <= wtr_cnt_reg - 10'h001;
    end
  end

  // Protocol failure: bad channel or far bridge mismatch, either held too long
  assign fop_bad = (aps_rx_reg.chan > nw) ||
                   (ctrl_reg.bidir && sel_reg != 4'h0 &&
                    aps_rx_reg.bridge != sel_reg);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fop_cnt_reg           <= 32'h0000_0000;
      protocol_failure_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      fop_cnt_reg <= fop_bad ? ((fop_cnt_reg == 32'(FOP_CYC)) ? fop_cnt_reg
                     : fop_cnt_reg + 32'h0000_0001) : 32'h0000_0000;
      protocol_failure_flag <= fop_bad &&
                               (fop_cnt_reg == 32'(FOP_CYC));
    end
  end

  // Switch event and duration counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_cnt_reg  <= 32'h0000_0000;
      dur_cnt_reg <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (sel_next != sel_reg && sel_next != 4'h0)
        ev_cnt_reg <= ev_cnt_reg + 32'h0000_0001;
      if (sel_reg != 4'h0 && tick)
        dur_cnt_reg <= dur_cnt_reg + 32'h0000_0001;
    end
  end

  // Data paths, all outputs registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      norm_out <= '0;
      work_out <= '0;
      prot_out <= '0;
      xtra_out <= '0;
      test_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < N_CH; i++)
      begin
        work_out[i] <= fwd(cap_reg[N_CH + i], ckd_reg[N_CH + i]);
        if (sel_reg == 4'(i + 1))
          norm_out[i] <= fwd(cap_reg[IP], ckd_reg[IP]);
        else
          norm_out[i] <= fwd(cap_reg[i], ckd_reg[i]);
      end
      if (s2_reg[IX].ck && !ckd_reg[IX])
        test_reg <= {test_reg[6:0], test_reg[7] ~^ test_reg[5]};
      if (ctrl_reg.arch_1p1)
        prot_out <= fwd(cap_reg[N_CH], ckd_reg[N_CH]);
      else if (sel_reg != 4'h0)
        prot_out <= fwd(cap_reg[N_CH + int'(sel_reg) - 1],
                        ckd_reg[N_CH + int'(sel_reg) - 1]);
      else if (ctrl_reg.spare_en)
        prot_out <= fwd(cap_reg[IX], ckd_reg[IX]);
      else
        case (ctrl_reg.null_mode)
          lsps_pkg::NULL_NORMAL:
            prot_out <= (ctrl_reg.null_ch < 4'(N_CH)) ?
              fwd(cap_reg[N_CH + int'(ctrl_reg.null_ch)],
                  ckd_reg[N_CH + int'(ctrl_reg.null_ch)]) :
              fwd(cap_reg[N_CH], ckd_reg[N_CH]);
          lsps_pkg::NULL_TEST:
            prot_out <= '{data: test_reg, ck: ckd_reg[IX],
                          fs: cap_reg[IX].fs, ssf: 1'b0};
          default:
            prot_out <= '{data: 8'hFF, ck: ckd_reg[IX],
                          fs: cap_reg[IX].fs, ssf: 1'b0};
        endcase
      if (sel_reg != 4'h0)
        xtra_out <= '{data: 8'hFF, ck: ckd_reg[IP],
                      fs: cap_reg[IP].fs, ssf: 1'b1};
      else
        xtra_out <= fwd(cap_reg[IP], ckd_reg[IP]);
    end
  end

  // APB slave, wait states only while clk_en is low
  assign wr_en   = psel && penable && pwrite && clk_en;
  assign pready  = clk_en;
  assign pslverr = psel && penable && (paddr[1:0] != 2'b00 ||
                   paddr > lsps_pkg::ADDR_INTMASK);
  assign int_set = {state_reg == lsps_pkg::ST_WTR &&
                    state_next != lsps_pkg::ST_WTR,
                    fop_bad && fop_cnt_reg == 32'(FOP_CYC) &&
                    !protocol_failure_flag,
                    sel_next != sel_reg && sel_next != 4'h0};
  assign irq     = |(int_stat_reg & int_mask_reg);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg       <= lsps_pkg::CTRL_RST;
      cmd_code_reg   <= lsps_pkg::CMD_CLR;
      cmd_ch_reg     <= 4'h0;
      wtr_period_reg <= lsps_pkg::WTR_RST;
      int_mask_reg   <= '0;
    end
    else if (wr_en && !pslverr)
    begin
      case (paddr)
        lsps_pkg::ADDR_CTRL:    ctrl_reg <= pwdata[11:0];
        lsps_pkg::ADDR_CMD:
        begin
          cmd_code_reg <= pwdata[2:0];
          cmd_ch_reg   <= pwdata[7:4];
        end
        lsps_pkg::ADDR_WTR:     wtr_period_reg <= pwdata[9:0];
        lsps_pkg::ADDR_INTMASK: int_mask_reg <= pwdata[INT_W_L-1:0];
        default:                int_mask_reg <= int_mask_reg;
      endcase
    end
  end

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_reg <= '0;
    else if (clk_en)
    begin
      if (wr_en && !pslverr && paddr == lsps_pkg::ADDR_INTSTAT)
        int_stat_reg <= (int_stat_reg & ~pwdata[INT_W_L-1:0]) | int_set;
      else
        int_stat_reg <= int_stat_reg | int_set;
    end
  end

  always_comb
  begin
    case (paddr)
      lsps_pkg::ADDR_CTRL:    rdata = {20'h0_0000, ctrl_reg};
      lsps_pkg::ADDR_CMD:     rdata = {24'h00_0000, cmd_ch_reg, 1'b0,
                                       cmd_code_reg};
      lsps_pkg::ADDR_WTR:     rdata = {22'h00_0000, wtr_period_reg};
      lsps_pkg::ADDR_STATUS:  rdata = {3'h0, aps_rx_reg, 7'h00,
                                       protocol_failure_flag, 1'b0,
                                       state_reg, sel_reg};
      lsps_pkg::ADDR_EVCNT:   rdata = ev_cnt_reg;
      lsps_pkg::ADDR_DURCNT:  rdata = dur_cnt_reg;
      lsps_pkg::ADDR_INTSTAT: rdata = {29'h0000_0000, int_stat_reg};
      lsps_pkg::ADDR_INTMASK: rdata = {29'h0000_0000, int_mask_reg};
      default:                rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable)
      prdata <= pslverr ? 32'h0000_0000 : rdata;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !clk_en);

  sequence fail_w1_s;
    ctrl_reg.arch_1p1 && cmd_code_reg == lsps_pkg::CMD_CLR &&
    !cap_reg[IP].ssf && $rose(cap_reg[0].ssf);
  endsequence

  chk_xtra_ais_force: assert property (
    sel_reg != 4'h0 |=> xtra_out.data == 8'hFF && xtra_out.ssf)
    else $error("spare output not forced to all ones");
  chk_prot_bridge_one: assert property (
    ctrl_reg.arch_1p1 |=> prot_out.data == $past(cap_reg[N_CH].data))
    else $error("protection output not bridged from normal one");
  chk_work_from_norm: assert property (
    1'b1 |=> work_out[0].data == $past(cap_reg[N_CH].data))
    else $error("working output not from its normal input");
  chk_norm_select_work: assert property (
    sel_reg == 4'h0 |=> norm_out[0].data == $past(cap_reg[0].data))
    else $error("normal output not from working section");
  chk_null_all_ones: assert property (
    !ctrl_reg.arch_1p1 && sel_reg == 4'h0 && !ctrl_reg.spare_en &&
    ctrl_reg.null_mode == lsps_pkg::NULL_ONES |=> prot_out.data == 8'hFF)
    else $error("null signal missing on protection output");
  chk_lockout_hold: assert property (
    cmd_code_reg == lsps_pkg::CMD_LO |=> sel_reg == 4'h0)
    else $error("selector moved under lockout");
  chk_fail_switch_fast: assert property (
    fail_w1_s |-> ##[1:2] sel_reg == 4'h1)
    else $error("fail on working one not switched in time");
  chk_wtr_hold_sel: assert property (
    state_reg == lsps_pkg::ST_WTR && wtr_cnt_reg != 10'h000 &&
    cmd_code_reg == lsps_pkg::CMD_CLR |=> $stable(sel_reg))
    else $error("selector reverted before wait period ended");
  chk_event_count_inc: assert property (
    sel_reg == 4'h0 ##1 sel_reg != 4'h0 |->
      ev_cnt_reg == $past(ev_cnt_reg) + 32'h0000_0001)
    else $error("switch event not counted");

endmodule

// ### tb/lsps_far_end.sv
`timescale 1ns/1ps
// Far-end timing: free running link clock and frame start
module lsps_far_end (
  output logic ck,
  output logic fs
);
  int n = 0;
  initial
  begin
    ck = 1'b0;
    fs = 1'b0;
  end
  always #80 ck = ~ck;
  always @(negedge ck)
  begin
    n  <= n + 1;
    fs <= (n % 8 == 7);
  end
endmodule

// ### tb/lsps_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module lsps_tb_top;
  logic                        pclk = 1'b0;
  logic                        presetn = 1'b0;
  logic                        psel = 1'b0;
  logic                        penable = 1'b0;
  logic                        pwrite = 1'b0;
  logic [7:0]                  paddr = 8'h00;
  logic [31:0]                 pwdata = 32'h0000_0000;
  logic [31:0]                 prdata;
  logic [31:0]                 rd;
  logic                        pready;
  logic                        pslverr;
  logic                        err;
  logic                        irq;
  logic                        fop;
  logic [12:0]                 aps_out;
  logic [12:0]                 aps = 13'h0000;
  logic                        ck;
  logic                        fs;
  logic [1:0][7:0]             wd = 16'h0000;
  logic [1:0][7:0]             nd = 16'h0000;
  logic [7:0]                  pd = 8'h00;
  logic [7:0]                  xd = 8'h00;
  logic [1:0]                  wf = 2'b00;
  int                          seed = 3;
  int                          miscompares = 0;
  int                          total_checks = 0;
  int                          cyc = 0;
  lsps_pkg::lsps_cp_in_t [1:0]  work_in;
  lsps_pkg::lsps_cp_in_t [1:0]  norm_in;
  lsps_pkg::lsps_cp_in_t        prot_in;
  lsps_pkg::lsps_cp_in_t        xtra_in;
  lsps_pkg::lsps_cp_out_t [1:0] norm_out;
  lsps_pkg::lsps_cp_out_t [1:0] work_out;
  lsps_pkg::lsps_cp_out_t       prot_out;
  lsps_pkg::lsps_cp_out_t       xtra_out;

  always #5 pclk = ~pclk;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      work_in[i] = {wd[i], ck, fs, wf[i], 1'b0};
      norm_in[i] = {nd[i], ck, fs, 2'b00};
    end
  end
  assign prot_in = {pd, ck, fs, 2'b00};
  assign xtra_in = {xd, ck, fs, 2'b00};

  lsps_far_end i_lsps_far_end (.ck(ck), .fs(fs));

  lsps_core #(.N_CH(2), .TICK_CYC(20), .FOP_CYC(10)) i_lsps_core (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .work_in(work_in), .norm_in(norm_in), .prot_in(prot_in),
    .xtra_in(xtra_in), .aps_rx(aps), .norm_out(norm_out),
    .work_out(work_out), .prot_out(prot_out), .xtra_out(xtra_out),
    .aps_tx(aps_out), .protocol_failure_flag(fop));

  // Signalling word in the order req, channel, bridge, architecture
  function automatic logic [12:0] exp_aps(input logic [3:0] req,
                                          input logic [3:0] chan,
                                          input logic [3:0] bridge,
                                          input logic       arch_n);
    return {req, chan, bridge, arch_n};
  endfunction

  task automatic conclude;
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic settle;
    repeat (40) @(posedge pclk);
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, lsps_pkg::ADDR_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0005)
    apb(1'b0, lsps_pkg::ADDR_WTR, 32'h0000_0000);
    `CHK(rd, 32'h0000_012C)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b1, lsps_pkg::ADDR_INTMASK, 32'h0000_0007);
    for (int i = 0; i < 4; i++)
    begin
      {wd, nd, pd, xd} <= 48'({$random(seed), $random(seed)});
      settle();
      apb(1'b1, lsps_pkg::ADDR_CTRL, 32'h0000_0005 | (i[0] << 1));
      apb(1'b1, lsps_pkg::ADDR_WTR, 32'(240 * (3 - i)));
      `CHK({work_out[1].data, work_out[0].data}, nd)
      `CHK(prot_out.data, nd[0])
      `CHK({norm_out[1].data, norm_out[0].data}, wd)
    end
    // Bidirectional with a silent far end: bridge mismatch flags failure
    wf <= 2'b01;
    settle();
    `CHK(norm_out[0].data, pd)
    `CHK({xtra_out.data, xtra_out.ssf}, 9'h1FF)
    `CHK(irq, 1'b1)
    `CHK(fop, 1'b1)
    apb(1'b1, lsps_pkg::ADDR_INTSTAT, 32'h0000_0003);
    `CHK(irq, 1'b0)
    wf <= 2'b00;
    settle();
    `CHK(norm_out[0].data, wd[0])
    apb(1'b1, lsps_pkg::ADDR_INTSTAT, 32'h0000_0007);
    apb(1'b1, lsps_pkg::ADDR_CMD, 32'h0000_0002);
    settle();
    `CHK(norm_out[0].data, pd)
    `CHK(aps_out, exp_aps(lsps_pkg::REQ_FS, 4'h1, 4'h1, 1'b0))
    apb(1'b1, lsps_pkg::ADDR_CMD, 32'h0000_0001);
    wf <= 2'b01;
    settle();
    `CHK(norm_out[0].data, wd[0])
    wf <= 2'b00;
    apb(1'b1, lsps_pkg::ADDR_CMD, 32'h0000_0000);
    // Far end asks for a forced switch and bridges channel one
    aps <= exp_aps(lsps_pkg::REQ_FS, 4'h1, 4'h1, 1'b0);
    settle();
    `CHK(norm_out[0].data, pd)
    `CHK(fop, 1'b0)
    aps <= 13'h0000;
    settle();
    `CHK(norm_out[0].data, wd[0])
    // Non-revertive: stays on protection after the fail clears
    apb(1'b1, lsps_pkg::ADDR_CTRL, 32'h0000_0001);
    wf <= 2'b01;
    settle();
    wf <= 2'b00;
    settle();
    `CHK(norm_out[0].data, pd)
    apb(1'b1, lsps_pkg::ADDR_CTRL, 32'h0000_000C);
    settle();
    `CHK(prot_out.data, xd)
    apb(1'b1, lsps_pkg::ADDR_WTR, 32'h0000_0003);
    wf <= 2'b10;
    settle();
    `CHK(norm_out[1].data, pd)
    `CHK(prot_out.data, nd[1])
    wf <= 2'b00;
    settle();
    `CHK(norm_out[1].data, pd)
    apb(1'b1, lsps_pkg::ADDR_CTRL, 32'h0000_0004);
    repeat (3) settle();
    `CHK(prot_out.data, 8'hFF)
    apb(1'b1, lsps_pkg::ADDR_CTRL, 32'h0000_0444);
    settle();
    `CHK(prot_out.data, nd[1])
    conclude();
  end
endmodule
